// *** hdl/audio_port_pkg.sv ***
/*
 * Shared constants and types for the serial audio output port.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package audio_port_pkg;

	localparam int ADDR_W = 8;
	localparam int POS_W = 10;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SLOT = 8'h04;
	localparam logic [7:0] OFF_DELAY = 8'h08;
	localparam logic [7:0] OFF_CLK = 8'h0c;
	localparam logic [7:0] OFF_LEFT = 8'h10;
	localparam logic [7:0] OFF_RIGHT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	localparam int CTRL_MASTER = 0;
	localparam int CTRL_FMT_LO = 1;
	localparam int CTRL_VARIANT = 3;
	localparam int CTRL_WL_LO = 4;
	localparam int SLOT_TSEN = 0;
	localparam int SLOT_DRIVE = 1;
	localparam int SLOT_PULL = 2;
	localparam int SLOT_DIR = 3;
	localparam int SLOT_TRI = 4;
	localparam int DELAY_R_LO = 16;
	localparam int CLK_FRAME_LO = 16;
	localparam int STAT_FRAMES_LO = 16;

	localparam logic [4:0] WL_RESET = 5'h17;
	localparam logic [7:0] HALF_DIV_RESET = 8'h03;
	localparam logic [9:0] FRAME_RESET = 10'h040;
	localparam logic [9:0] POS_FIRST = 10'h001;
	localparam logic [9:0] POS_SECOND = 10'h002;

	typedef enum logic [1:0] {
		FMT_RIGHT = 2'h0,
		FMT_LEFT = 2'h1,
		FMT_I2S = 2'h2,
		FMT_PCM = 2'h3
	} fmt_e;

	typedef struct packed {
		logic tri_neg;
		logic pull_dir;
		logic pull_en;
		logic drive_en;
		logic tsen;
	} slot_cfg_s;

	localparam slot_cfg_s SLOT_RESET = 5'h02;

endpackage

// *** hdl/audio_serial_port.sv ***
/*
 * Serial audio output port with APB register access. Sends left and
 * right sample words on serial_data_out in five framing formats, as bit
 * clock master or slave. Assumes bclk_in and fs_in arrive from outside
 * the pclk domain and are far slower than pclk.
 */
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
module audio_serial_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [audio_port_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bclk_in,
	output logic bclk_out,
	output logic bclk_oe,
	input wire logic fs_in,
	output logic frame_sync,
	output logic frame_sync_oe,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic pull_up_en,
	output logic pull_down_en
);

	typedef logic [audio_port_pkg::POS_W-1:0] pos_t;

	function automatic logic in_win(input pos_t p, input pos_t s,
		input pos_t w);
		return (p >= s) && ((p - s) < w);
	endfunction

	function automatic logic pick_bit(input logic [31:0] d, input pos_t p,
		input pos_t s, input pos_t w);
		pos_t i;
		i = w - 10'h001 - (p - s);
		return d[i[4:0]];
	endfunction

	// Register file.
	logic master_reg;
	audio_port_pkg::fmt_e fmt_reg;
	logic variant_reg;
	logic [4:0] wl_reg;
	audio_port_pkg::slot_cfg_s slot_reg;
	pos_t ldelay_reg;
	pos_t rdelay_reg;
	logic [7:0] half_div_reg;
	pos_t frame_len_reg;
	logic [31:0] left_reg;
	logic [31:0] right_reg;
	logic [15:0] frames_reg;

	wire wr_en = psel && penable && pwrite;
	wire a_ctrl = paddr == audio_port_pkg::OFF_CTRL;
	wire a_slot = paddr == audio_port_pkg::OFF_SLOT;
	wire a_delay = paddr == audio_port_pkg::OFF_DELAY;
	wire a_clk = paddr == audio_port_pkg::OFF_CLK;
	wire a_left = paddr == audio_port_pkg::OFF_LEFT;
	wire a_right = paddr == audio_port_pkg::OFF_RIGHT;
	wire a_stat = paddr == audio_port_pkg::OFF_STATUS;
	wire mapped = a_ctrl | a_slot | a_delay | a_clk | a_left | a_right
		| a_stat;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_reg <= 1'b0;
			fmt_reg <= audio_port_pkg::FMT_I2S;
			variant_reg <= 1'b0;
			wl_reg <= audio_port_pkg::WL_RESET;
			slot_reg <= audio_port_pkg::SLOT_RESET;
			ldelay_reg <= '0;
			rdelay_reg <= '0;
			half_div_reg <= audio_port_pkg::HALF_DIV_RESET;
			frame_len_reg <= audio_port_pkg::FRAME_RESET;
			left_reg <= '0;
			right_reg <= '0;
		end else if (wr_en) begin
			if (a_ctrl) begin
				master_reg <= pwdata[audio_port_pkg::CTRL_MASTER];
				fmt_reg <= audio_port_pkg::fmt_e'(
					pwdata[audio_port_pkg::CTRL_FMT_LO +: 2]);
				variant_reg <= pwdata[audio_port_pkg::CTRL_VARIANT];
				wl_reg <= pwdata[audio_port_pkg::CTRL_WL_LO +: 5];
			end
			if (a_slot)
				slot_reg <= pwdata[4:0];
			if (a_delay) begin
				ldelay_reg <= pwdata[audio_port_pkg::POS_W-1:0];
				rdelay_reg <= pwdata[audio_port_pkg::DELAY_R_LO +:
					audio_port_pkg::POS_W];
			end
			if (a_clk) begin
				half_div_reg <= pwdata[7:0];
				frame_len_reg <= pwdata[audio_port_pkg::CLK_FRAME_LO +:
					audio_port_pkg::POS_W];
			end
			if (a_left)
				left_reg <= pwdata;
			if (a_right)
				right_reg <= pwdata;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Link pins: two flip-flops each, then a third bit clock stage for edge finding.
	logic bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Bit clock stages reset to its high idle level, so no false
			// rise follows reset; a host idling low costs one harmless fall.
			bclk_s1 <= 1'b1;
			bclk_s2 <= 1'b1;
			bclk_s3 <= 1'b1;
			fs_s1 <= 1'b0;
			fs_s2 <= 1'b0;
		end else begin
			bclk_s1 <= bclk_in;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			fs_s1 <= fs_in;
			fs_s2 <= fs_s1;
		end
	end

	// Master clock and frame generation from pclk.
	logic [7:0] div_cnt_reg;
	logic bclk_m_reg;
	pos_t mpos_reg;
	logic fs_m_reg;
	wire div_hit = master_reg && (div_cnt_reg == half_div_reg);
	wire m_rise = div_hit && !bclk_m_reg;
	wire m_fall = div_hit && bclk_m_reg;
	wire is_pcm = fmt_reg == audio_port_pkg::FMT_PCM;
	wire is_i2s = fmt_reg == audio_port_pkg::FMT_I2S;
	wire [audio_port_pkg::POS_W-1:0] half_len = frame_len_reg >> 1;
	wire [audio_port_pkg::POS_W-1:0] mpos_next =
		(mpos_reg >= frame_len_reg) ? audio_port_pkg::POS_FIRST :
		mpos_reg + audio_port_pkg::POS_FIRST;
	wire fs_m_next = is_pcm ? (mpos_next == audio_port_pkg::POS_FIRST) :
		((mpos_next <= half_len) ^ is_i2s);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= '0;
			bclk_m_reg <= 1'b0;
			mpos_reg <= '0;
			fs_m_reg <= 1'b0;
		end else if (!master_reg) begin
			div_cnt_reg <= '0;
			bclk_m_reg <= 1'b0;
			mpos_reg <= '0;
			fs_m_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01;
			if (div_hit)
				bclk_m_reg <= !bclk_m_reg;
			if (m_fall) begin
				mpos_reg <= mpos_next;
				fs_m_reg <= fs_m_next;
			end
		end
	end

	assign bclk_out = bclk_m_reg;
	assign bclk_oe = master_reg;
	assign frame_sync = fs_m_reg;
	assign frame_sync_oe = master_reg;

	// One framing engine serves both modes.
	wire rise_evt = master_reg ? m_rise : (bclk_s2 && !bclk_s3);
	wire fall_evt = master_reg ? m_fall : (!bclk_s2 && bclk_s3);
	wire fs_cur = master_reg ? fs_m_next : fs_s2;

	logic fs_prev_reg;
	pos_t pos_reg;
	logic [31:0] left_hold_reg, right_hold_reg;
	logic data_reg, active_reg, oe_reg, lsb_reg;

	// Half formats restart on each sync change, PCM on the sync pulse.
	wire new_half = is_pcm ? (fs_cur && !fs_prev_reg) :
		(fs_cur != fs_prev_reg);
	wire left_half = fs_cur ^ is_i2s;
	wire [audio_port_pkg::POS_W-1:0] pos_next = new_half ?
		audio_port_pkg::POS_FIRST :
		(&pos_reg ? pos_reg : pos_reg + audio_port_pkg::POS_FIRST);
	wire load_now = fall_evt && new_half && (is_pcm || left_half);
	wire [31:0] lw = load_now ? left_reg : left_hold_reg;
	wire [31:0] rw = load_now ? right_reg : right_hold_reg;

	wire [audio_port_pkg::POS_W-1:0] wl = {5'h00, wl_reg}
		+ audio_port_pkg::POS_FIRST;
	wire [audio_port_pkg::POS_W-1:0] rj_start = half_len - wl
		+ audio_port_pkg::POS_FIRST;
	wire [audio_port_pkg::POS_W-1:0] half_start =
		(fmt_reg == audio_port_pkg::FMT_RIGHT) ? rj_start :
		(fmt_reg == audio_port_pkg::FMT_LEFT) ? audio_port_pkg::POS_FIRST :
		audio_port_pkg::POS_SECOND;
	wire [audio_port_pkg::POS_W-1:0] pcm_start = variant_reg ?
		audio_port_pkg::POS_FIRST : audio_port_pkg::POS_SECOND;
	wire [audio_port_pkg::POS_W-1:0] start_l = !is_pcm ? half_start :
		slot_reg.tsen ? ldelay_reg + audio_port_pkg::POS_FIRST :
		pcm_start;
	wire [audio_port_pkg::POS_W-1:0] start_r = !is_pcm ? half_start :
		slot_reg.tsen ? rdelay_reg + audio_port_pkg::POS_FIRST :
		pcm_start + wl;

	wire hit_l = (is_pcm || left_half) && in_win(pos_next, start_l, wl);
	wire hit_r = (is_pcm || !left_half) && in_win(pos_next, start_r, wl);
	wire active_next = hit_l || hit_r;
	// MSB first; left wins if time slots overlap.
	wire bit_next = hit_l ? pick_bit(lw, pos_next, start_l, wl) :
		pick_bit(rw, pos_next, start_r, wl);
	wire lsb_next = hit_l ? (pos_next == start_l + wl - 10'h001) :
		(pos_next == start_r + wl - 10'h001);

	// Pull enable and tri-state options only apply with time slots on.
	wire drive_all = !slot_reg.tsen || slot_reg.drive_en;
	wire passive = !drive_all && slot_reg.pull_en;
	wire tri_mode = !drive_all && !slot_reg.pull_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_prev_reg <= 1'b0;
			pos_reg <= '0;
			left_hold_reg <= '0;
			right_hold_reg <= '0;
			data_reg <= 1'b0;
			active_reg <= 1'b0;
			oe_reg <= 1'b0;
			lsb_reg <= 1'b0;
			frames_reg <= '0;
		end else begin
			if (fall_evt) begin
				fs_prev_reg <= fs_cur;
				pos_reg <= pos_next;
				active_reg <= active_next;
				lsb_reg <= active_next && lsb_next;
				oe_reg <= active_next;
				// Bits change only here, so the host reads them stable
				// at the following rise.
				data_reg <= active_next ? bit_next :
					slot_reg.pull_dir;
			end else if (rise_evt && lsb_reg && !slot_reg.tri_neg) begin
				oe_reg <= 1'b0;
			end
			if (load_now) begin
				left_hold_reg <= left_reg;
				right_hold_reg <= right_reg;
				frames_reg <= frames_reg + 16'h0001;
			end
		end
	end

	assign serial_data_out = data_reg;
	assign serial_data_oe = drive_all || oe_reg;
	assign pull_up_en = passive && slot_reg.pull_dir;
	assign pull_down_en = passive && !slot_reg.pull_dir;

	// Read mux; the left and right words read back as written.
	wire [31:0] rd_ctrl = {23'h000000, wl_reg, variant_reg, fmt_reg,
		master_reg};
	wire [31:0] rd_slot = {27'h0000000, slot_reg};
	wire [31:0] rd_delay = {6'h00, rdelay_reg, 6'h00, ldelay_reg};
	wire [31:0] rd_clk = {6'h00, frame_len_reg, 8'h00, half_div_reg};
	wire [31:0] rd_stat = {frames_reg, 13'h0000, lsb_reg, left_half,
		active_reg};
	wire [31:0] rd_mux = a_ctrl ? rd_ctrl : a_slot ? rd_slot :
		a_delay ? rd_delay : a_clk ? rd_clk : a_left ? left_reg :
		a_right ? right_reg : a_stat ? rd_stat : 32'h00000000;

	// Taken in the setup cycle, so read data leave a flip-flop and still
	// stand through the zero-wait access phase.
	logic [31:0] prdata_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= '0;
		else if (psel && !penable)
			prdata_reg <= rd_mux;
	end
	assign prdata = prdata_reg;

	property p_slave_pins;
		@(posedge pclk) disable iff (!presetn)
		!master_reg |-> !bclk_oe && !frame_sync_oe;
	endproperty
	a_slave_pins: assert property (p_slave_pins)
		else $error("link clock or sync driven in slave mode");

	property p_reset_slave;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !master_reg && !bclk_oe;
	endproperty
	a_reset_slave: assert property (p_reset_slave)
		else $error("port not slave after reset");

	property p_reset_fmt;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> fmt_reg == audio_port_pkg::FMT_I2S;
	endproperty
	a_reset_fmt: assert property (p_reset_fmt)
		else $error("format not I2S after reset");

	property p_data_on_fall;
		@(posedge pclk) disable iff (!presetn)
		!fall_evt |=> $stable(serial_data_out);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall)
		else $error("data changed away from a falling edge");

	property p_idle_level;
		@(posedge pclk) disable iff (!presetn)
		fall_evt && !active_next |=>
			serial_data_out == slot_reg.pull_dir;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("idle data not at pull level");

	property p_always_driven;
		@(posedge pclk) disable iff (!presetn)
		(!slot_reg.tsen || slot_reg.drive_en) |-> serial_data_oe;
	endproperty
	a_always_driven: assert property (p_always_driven)
		else $error("data output released while drive enabled");

	property p_passive_pull;
		@(posedge pclk) disable iff (!presetn)
		slot_reg.tsen && !slot_reg.drive_en && slot_reg.pull_en |->
			(pull_up_en == slot_reg.pull_dir) &&
			(pull_down_en != slot_reg.pull_dir);
	endproperty
	a_passive_pull: assert property (p_passive_pull)
		else $error("pull resistor not selected by direction bit");

	property p_tri_idle;
		@(posedge pclk) disable iff (!presetn)
		tri_mode && !active_reg |-> !serial_data_oe;
	endproperty
	a_tri_idle: assert property (p_tri_idle)
		else $error("data output driven outside a word");

	property p_tri_rise;
		@(posedge pclk) disable iff (!presetn)
		tri_mode && !slot_reg.tri_neg && rise_evt && lsb_reg &&
			!fall_evt |=> !serial_data_oe;
	endproperty
	a_tri_rise: assert property (p_tri_rise)
		else $error("output not released on LSB rising edge");

	property p_pcm_b_msb;
		@(posedge pclk) disable iff (!presetn)
		fall_evt && new_half && is_pcm && variant_reg &&
			!slot_reg.tsen |=> active_reg && pos_reg == 10'h001;
	endproperty
	a_pcm_b_msb: assert property (p_pcm_b_msb)
		else $error("PCM B left MSB not at first rise");

endmodule

// *** sim/audio_host_model.sv ***
/*
 * Host model for the serial audio port in slave mode: makes bit clock
 * and frame sync and samples the data wire at each bit clock rise.
 * Assumes frames of 64 bit clocks, called back to back by the bench.
 */
`timescale 1ns/1ns
module audio_host_model (
	input wire logic sd,
	output logic bclk,
	output logic fs
);
	logic [64:1] cap;
	initial begin
		bclk = 1'b1;
		fs = 1'b0;
		cap = '0;
	end
	// The bit clock stands high between frames, as a stopped host would.
	task automatic frame(input logic pulse, input logic first);
		for (int i = 1; i <= 64; i++) begin
			bclk = 1'b0;
			if (i == 1)
				fs = pulse ? 1'b1 : first;
			else if (pulse && i == 2)
				fs = 1'b0;
			else if (!pulse && i == 33)
				fs = ~first;
			#200;
			bclk = 1'b1;
			cap[i] = sd;
			#200;
		end
	endtask
endmodule

// *** sim/test_audio_serial_port.sv ***
/*
 * Self-checking bench for the serial audio port: APB tasks, a host
 * model for slave framing, then a master clock check.
 * Assumes the design package and the host model are compiled first.
 */
`timescale 1ns/1ns
module test_audio_serial_port;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic bclk_in, fs_in, bclk_out, bclk_oe, frame_sync, frame_sync_oe;
	logic serial_data_out, serial_data_oe, pull_up_en, pull_down_en;
	logic sd_wire, e, pv;
	logic [64:1] ex;
	int fails = 0;
	int n_compared = 0;
	int cnt;
	// RJ, LJ, LJ resting high, I2S, PCM A, PCM B, slots driven/pull/open,
	// open with release on the LSB rise, pull-down.
	logic [31:0] ctrl_t [11] = '{32'h70, 32'h72, 32'h72, 32'h74, 32'h76,
		32'h7e, 32'h76, 32'h76, 32'h76, 32'h76, 32'h76};
	logic [31:0] slot_t [11] = '{32'h02, 32'h02, 32'h0a, 32'h02, 32'h02,
		32'h02, 32'h0b, 32'h0d, 32'h11, 32'h01, 32'h05};
	int l0_t [11] = '{25, 1, 1, 2, 2, 1, 21, 21, 21, 21, 21};
	int r0_t [11] = '{57, 33, 33, 34, 10, 9, 41, 41, 41, 41, 41};
	logic [0:10] pulse_v = 11'h07f;
	logic [0:10] first_v = 11'h77f;
	logic [0:10] rest_v = {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
		1'b1, 1'bz, 1'bz, 1'b0};

	// The wire level seen by the host: driver first, then internal pull.
	assign sd_wire = serial_data_oe ? serial_data_out :
		pull_up_en ? 1'b1 : pull_down_en ? 1'b0 : 1'bz;

	audio_serial_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bclk_in(bclk_in), .bclk_out(bclk_out),
		.bclk_oe(bclk_oe), .fs_in(fs_in), .frame_sync(frame_sync),
		.frame_sync_oe(frame_sync_oe), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en));
	audio_host_model host (.sd(sd_wire), .bclk(bclk_in), .fs(fs_in));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic end_of_test;
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp,
		input string msg);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [64:1] frame_exp(int l0, int r0, logic rest);
		logic [64:1] v;
		logic [7:0] lw;
		logic [7:0] rw;
		v = {64{rest}};
		lw = 8'ha5;
		rw = 8'h3c;
		for (int k = 0; k < 8; k++) begin
			v[l0 + k] = lw[7 - k];
			v[r0 + k] = rw[7 - k];
		end
		return v;
	endfunction

	initial begin
		#2000000;
		fails++;
		end_of_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, audio_port_pkg::OFF_CTRL, 32'h0);
		check(64'(q), 64'h174, "ctrl reset");
		apb(1'b0, audio_port_pkg::OFF_SLOT, 32'h0);
		check(64'(q), 64'h2, "slot reset");
		apb(1'b0, audio_port_pkg::OFF_CLK, 32'h0);
		check(64'(q), 64'h400003, "clk reset");
		apb(1'b0, 8'h1c, 32'h0);
		check(64'({e, q}), 64'h100000000, "unmapped read");
		check(64'({bclk_oe, serial_data_oe}), 64'h1, "slave oe");
		apb(1'b1, audio_port_pkg::OFF_LEFT, 32'ha5);
		apb(1'b1, audio_port_pkg::OFF_RIGHT, 32'h3c);
		apb(1'b1, audio_port_pkg::OFF_DELAY, 32'h280014);
		apb(1'b0, audio_port_pkg::OFF_DELAY, 32'h0);
		check(64'(q), 64'h280014, "delay readback");
		for (int m = 0; m < 11; m++) begin
			apb(1'b1, audio_port_pkg::OFF_CTRL, ctrl_t[m]);
			apb(1'b1, audio_port_pkg::OFF_SLOT, slot_t[m]);
			#17;
			repeat (3) host.frame(pulse_v[m], first_v[m]);
			ex = frame_exp(l0_t[m], r0_t[m], rest_v[m]);
			check(64'(host.cap[32:1]), 64'(ex[32:1]), "first half");
			check(64'(host.cap[64:33]), 64'(ex[64:33]), "second half");
		end
		apb(1'b1, audio_port_pkg::OFF_SLOT, 32'h02);
		apb(1'b1, audio_port_pkg::OFF_CTRL, 32'h73);
		repeat (4) @(posedge pclk);
		check(64'({bclk_oe, frame_sync_oe}), 64'h3, "master oe");
		cnt = 0;
		pv = bclk_out;
		repeat (64) begin
			@(posedge pclk);
			if (bclk_out !== pv)
				cnt++;
			pv = bclk_out;
		end
		check(64'(cnt), 64'h10, "bit clock rate");
		cnt = 0;
		pv = frame_sync;
		repeat (1024) begin
			@(posedge pclk);
			if (frame_sync !== pv)
				cnt++;
			pv = frame_sync;
		end
		check(64'(cnt), 64'h4, "frame rate");
		end_of_test();
	end
endmodule
